// ==== pwp_protect.sv ====
// Purpose: Unlock key and group write-lock mask inside the command handler
// Assumes: Requests and boot loads come from logic on CLK_SYS
// Notes:   One request per cycle, answered on the following cycle unless a boot load shares its cycle
//
// How it works
// - A 16-bit key, while armed, blocks mask writes and saving to NVM.
// - With key zero, save is allowed and key writes replace the key.
// - Nonzero boot key arms the block until the host writes that key.
// - Three mismatches without a match lock key access until power-on reset.
// - Key reads return a state code, never the key itself.
// - The key is command FAh, word write and word read.
// - The mask is command FBh, 16 bits, word write and word read.
// - Each of bits 13 to 8 guards only its own command group.
// - Bits 13 to 8 clear defer to WRITE_PROTECT; set means read-only.
// - Bit 15 makes mask and key read-only; otherwise key and bit 1 govern.
// - Bit 15 saved while set locks the mask until power-on reset.
// - Bit 14 guards WRITE_PROTECT, which is otherwise always writable.
// - Bit 13 guards trim, loop scale, current gain and offset.
// - Bit 12 guards output mode and output setpoint.
// - Bit 11 guards output max, min, fault limits and responses.
// - Bit 10 guards output, current, temperature warnings and alert mask.
// - Bit 9 guards current, temperature fault limits, responses, fault simulation.
// - Bit 1 guards the key; saved with nonzero key it locks the mask.
// - Bit 0 makes the save command read-only at all times.
// - Bit 8 guards margin high, margin low and transition rate.
`timescale 1ns/100ps
`include "pwp_regs.svh"

module pwp_protect (
   input  wire logic              CLK_SYS,
   input  wire logic              RESET_N,
   input  wire pwp_pkg::pwp_req_t REQ,
   input  wire logic              BOOT_LOAD,
   input  wire logic [15:0]       BOOT_KEY,
   input  wire logic [15:0]       BOOT_MASK,
   output pwp_pkg::pwp_rsp_t      RSP,
   output logic [15:0]            MASK_OUT,
   output logic                   KEY_ARMED,
   output logic                   KEY_LOCKOUT
);
   import pwp_pkg::*;

   pwp_state_t st_q;
   pwp_state_t st_d;

   // Group of a guarded command: {guarded, bit index}
   function automatic logic [4:0] group_of(input logic [7:0] code);
      logic [4:0] g;
      g = {1'b0, 4'h0};
      if (code == `PWP_CMD_LOCK_SETPOINT_BIT_TRIM  ||
          code == `PWP_CMD_SCALE_LOOP ||
          code == `PWP_CMD_CAL_GAIN   ||
          code == `PWP_CMD_CAL_OFFSET) begin
         g = {1'b1, `PWP_BIT_TRIM};
      end else if (code == `PWP_CMD_LOCK_SETPOINT_BIT_MODE ||
                   code == `PWP_CMD_LOCK_SETPOINT_BIT_SETPOINT) begin
         g = {1'b1, `PWP_BIT_SETPOINT};
      end else if (code == `PWP_CMD_LOCK_SETPOINT_BIT_MAX     ||
                   code == `PWP_CMD_LOCK_SETPOINT_BIT_MIN     ||
                   code == `PWP_CMD_OV_FLT_LIMIT ||
                   code == `PWP_CMD_OV_FLT_RESP  ||
                   code == `PWP_CMD_UV_FLT_LIMIT ||
                   code == `PWP_CMD_UV_FLT_RESP) begin
         g = {1'b1, `PWP_BIT_OUT_FAULT};
      end else if (code == `PWP_CMD_OV_WARN ||
                   code == `PWP_CMD_UV_WARN ||
                   code == `PWP_CMD_OC_WARN ||
                   code == `PWP_CMD_OT_WARN ||
                   code == `PWP_CMD_ALERT_MASK) begin
         g = {1'b1, `PWP_BIT_WARNING};
      end else if (code == `PWP_CMD_OC_FLT_LIMIT ||
                   code == `PWP_CMD_OC_FLT_RESP  ||
                   code == `PWP_CMD_OT_FLT_LIMIT ||
                   code == `PWP_CMD_OT_FLT_RESP  ||
                   code == `PWP_CMD_SIM_FAULT) begin
         g = {1'b1, `PWP_BIT_CUR_TEMP};
      end else if (code == `PWP_CMD_MARGIN_HIGH ||
                   code == `PWP_CMD_MARGIN_LOW  ||
                   code == `PWP_CMD_TRANS_RATE) begin
         g = {1'b1, `PWP_BIT_MARGIN};
      end else begin
         // Unlisted codes fall back on standard protection only
         g = {1'b0, 4'h0};
      end
      return g;
   endfunction : group_of

   // Terms that make a stored mask permanent; shared by boot and save
   function automatic logic perm_term(input logic [15:0] mask,
                                      input logic        key_set);
      logic p;
      p = mask[`PWP_BIT_SELF] | (mask[`PWP_BIT_KEY] & key_set);
      return p;
   endfunction : perm_term

   // Read-back code; the key value itself never leaves the block
   function automatic logic [15:0] key_code(input logic       armed,
                                            input logic       lockout,
                                            input logic [1:0] bad);
      logic [15:0] c;
      c = `PWP_RD_UNLOCKED;
      if (lockout) begin
         c = `PWP_RD_LOCKED_3;
      end else if (armed) begin
         case (bad)
            2'h0:    c = `PWP_RD_LOCKED_0;
            2'h1:    c = `PWP_RD_LOCKED_1;
            2'h2:    c = `PWP_RD_LOCKED_2;
            default: c = `PWP_RD_LOCKED_3;
         endcase
      end
      return c;
   endfunction : key_code

   logic [4:0]  grp;
   logic        mask_ro;
   logic        key_ro;
   logic        save_ro;
   logic        grp_ro;
   logic        key_match;
   logic        key_nonzero;
   logic [1:0]  bad_next;

   always_comb begin
      grp         = group_of(REQ.code);
      key_nonzero = (st_q.key != `PWP_ZERO_WORD);
      key_match   = (REQ.wdata == st_q.key);
      bad_next    = st_q.bad_cnt + 2'h1;
      // Mask is read-only by its own bit, the armed key or a stored lock
      mask_ro = st_q.mask[`PWP_BIT_SELF] | st_q.armed | st_q.perm;
      // Key is read-only by bit 15 or its own guard bit
      key_ro  = st_q.mask[`PWP_BIT_SELF] | st_q.mask[`PWP_BIT_KEY];
      // Save needs bit 0 clear, the key disarmed and standard protection off
      save_ro = st_q.mask[`PWP_BIT_SAVE] | st_q.armed | REQ.std_wp_block;
      // Each group sees only its own mask bit
      grp_ro  = st_q.mask[grp[3:0]] | REQ.std_wp_block;
   end

   always_comb begin
      st_d           = st_q;
      st_d.rsp.valid = 1'b0;
      st_d.rsp.hit   = 1'b0;
      st_d.rsp.accept = 1'b0;
      st_d.rsp.rdata = `PWP_ZERO_WORD;

      if (BOOT_LOAD) begin
         // Boot values come from NVM; a nonzero key arms the block
         st_d.key   = BOOT_KEY;
         st_d.mask  = BOOT_MASK;
         st_d.armed = (BOOT_KEY != `PWP_ZERO_WORD);
         // A mask stored with bit 15, or bit 1 with a nonzero key, stays locked
         st_d.perm  = st_q.perm |
                      perm_term(BOOT_MASK, BOOT_KEY != `PWP_ZERO_WORD);
         st_d.bad_cnt = 2'h0;
      end else if (REQ.valid) begin
         st_d.rsp.valid = 1'b1;
         if (REQ.code == `PWP_CMD_KEY) begin
            st_d.rsp.hit = 1'b1;
            if (!REQ.write) begin
               st_d.rsp.rdata = key_code(st_q.armed, st_q.lockout, st_q.bad_cnt);
            end else if (key_ro) begin
               st_d.rsp.accept = 1'b0;
            end else if (st_q.lockout) begin
               st_d.rsp.accept = 1'b0;
            end else if (st_q.armed) begin
               if (key_match) begin
                  st_d.armed      = 1'b0;
                  st_d.bad_cnt    = 2'h0;
                  st_d.rsp.accept = 1'b1;
               end else begin
                  st_d.bad_cnt = bad_next;
                  if (bad_next == `PWP_BAD_LIMIT) begin
                     st_d.lockout = 1'b1;
                  end
               end
            end else begin
               // Disarmed: the write becomes the active key
               st_d.key        = REQ.wdata;
               st_d.bad_cnt    = 2'h0;
               st_d.rsp.accept = 1'b1;
            end
         end else if (REQ.code == `PWP_CMD_MASK) begin
            st_d.rsp.hit = 1'b1;
            if (!REQ.write) begin
               st_d.rsp.rdata = st_q.mask;
            end else if (!mask_ro) begin
               st_d.mask       = REQ.wdata;
               st_d.rsp.accept = 1'b1;
            end
         end else if (REQ.code == `PWP_CMD_WRITE_PROTECT) begin
            // Standard protection never guards its own command
            st_d.rsp.accept = REQ.write & ~st_q.mask[`PWP_BIT_WP];
         end else if (REQ.code == `PWP_CMD_STORE_ALL) begin
            st_d.rsp.accept = REQ.write & ~save_ro;
            if (REQ.write && !save_ro) begin
               // Saving bit 15, or bit 1 with a nonzero key, locks the mask
               st_d.perm = st_q.perm | perm_term(st_q.mask, key_nonzero);
            end
         end else if (grp[4]) begin
            st_d.rsp.accept = REQ.write & ~grp_ro;
         end else begin
            st_d.rsp.accept = REQ.write & ~REQ.std_wp_block;
         end
      end
   end

   // Lockout and stored lock only clear at power-on reset
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         st_q.key        <= `PWP_KEY_RESET;
         st_q.mask       <= `PWP_MASK_RESET;
         st_q.armed      <= 1'b0;
         st_q.lockout    <= 1'b0;
         st_q.bad_cnt    <= 2'h0;
         st_q.perm       <= 1'b0;
         st_q.rsp.valid  <= 1'b0;
         st_q.rsp.hit    <= 1'b0;
         st_q.rsp.accept <= 1'b0;
         st_q.rsp.rdata  <= `PWP_ZERO_WORD;
      end else begin
         st_q <= st_d;
      end
   end

   assign RSP         = st_q.rsp;
   assign MASK_OUT    = st_q.mask;
   assign KEY_ARMED   = st_q.armed;
   assign KEY_LOCKOUT = st_q.lockout;

endmodule : pwp_protect

// ==== pwp_regs.svh ====
// Purpose: Constants for the unlock key and group write-lock mask logic
// Assumes: Command codes are 8-bit PMBus codes, data words are 16 bits
// Notes:   Included by the package; definitions only
`ifndef PWP_REGS_SVH
`define PWP_REGS_SVH

// Command codes of the two protection registers
`define PWP_CMD_KEY            8'hFA
`define PWP_CMD_MASK           8'hFB

// Standard PMBus command codes; the mask guards all but OPERATION
`define PWP_CMD_OPERATION      8'h01
`define PWP_CMD_WRITE_PROTECT  8'h10
`define PWP_CMD_STORE_ALL      8'h15
`define PWP_CMD_ALERT_MASK     8'h1B
`define PWP_CMD_LOCK_SETPOINT_BIT_MODE      8'h20
`define PWP_CMD_LOCK_SETPOINT_BIT_SETPOINT  8'h21
`define PWP_CMD_LOCK_SETPOINT_BIT_TRIM      8'h22
`define PWP_CMD_LOCK_SETPOINT_BIT_MAX       8'h24
`define PWP_CMD_MARGIN_HIGH    8'h25
`define PWP_CMD_MARGIN_LOW     8'h26
`define PWP_CMD_TRANS_RATE     8'h27
`define PWP_CMD_SCALE_LOOP     8'h29
`define PWP_CMD_LOCK_SETPOINT_BIT_MIN       8'h2B
`define PWP_CMD_CAL_GAIN       8'h38
`define PWP_CMD_CAL_OFFSET     8'h39
`define PWP_CMD_OV_FLT_LIMIT   8'h40
`define PWP_CMD_OV_FLT_RESP    8'h41
`define PWP_CMD_OV_WARN        8'h42
`define PWP_CMD_UV_WARN        8'h43
`define PWP_CMD_UV_FLT_LIMIT   8'h44
`define PWP_CMD_UV_FLT_RESP    8'h45
`define PWP_CMD_OC_FLT_LIMIT   8'h46
`define PWP_CMD_OC_FLT_RESP    8'h47
`define PWP_CMD_OC_WARN        8'h4A
`define PWP_CMD_OT_FLT_LIMIT   8'h4F
`define PWP_CMD_OT_FLT_RESP    8'h50
`define PWP_CMD_OT_WARN        8'h51
`define PWP_CMD_SIM_FAULT      8'hF1

// Mask bit positions
`define PWP_BIT_SELF           4'hF
`define PWP_BIT_WP             4'hE
`define PWP_BIT_TRIM           4'hD
`define PWP_BIT_SETPOINT       4'hC
`define PWP_BIT_OUT_FAULT      4'hB
`define PWP_BIT_WARNING        4'hA
`define PWP_BIT_CUR_TEMP       4'h9
`define PWP_BIT_MARGIN         4'h8
`define PWP_BIT_KEY            4'h1
`define PWP_BIT_SAVE           4'h0

// Key read-back codes
`define PWP_RD_UNLOCKED        16'h0000
`define PWP_RD_LOCKED_0        16'h000F
`define PWP_RD_LOCKED_1        16'h001F
`define PWP_RD_LOCKED_2        16'h002F
`define PWP_RD_LOCKED_3        16'h00FF

// Mismatches that cause the lockout, and reset values
`define PWP_BAD_LIMIT          2'h3
`define PWP_KEY_RESET          16'h0000
`define PWP_MASK_RESET         16'h0000
`define PWP_ZERO_WORD          16'h0000

`endif

// ==== pwp_pkg.sv ====
// Purpose: Types for the unlock key and group write-lock mask logic
// Assumes: pwp_regs.svh is found on the include path
// Notes:   Request and answer words of the command handler port
`include "pwp_regs.svh"

package pwp_pkg;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] wdata;
      logic        std_wp_block;
   } pwp_req_t;

   typedef struct packed {
      logic        valid;
      logic        hit;
      logic        accept;
      logic [15:0] rdata;
   } pwp_rsp_t;

   typedef struct packed {
      logic [15:0] key;
      logic [15:0] mask;
      logic        armed;
      logic        lockout;
      logic [1:0]  bad_cnt;
      logic        perm;
      pwp_rsp_t    rsp;
   } pwp_state_t;

endpackage : pwp_pkg

// ==== pwp_monitor.sv ====
// Purpose: Port checks on the key and group write-lock mask block
// Assumes: One request per cycle, answered one cycle later
// Notes:   Bound to every pwp_protect instance
`timescale 1ns/100ps
module pwp_monitor (
   input wire logic              CLK_SYS,
   input wire logic              RESET_N,
   input wire pwp_pkg::pwp_req_t REQ,
   input wire logic              BOOT_LOAD,
   input wire logic [15:0]       BOOT_KEY,
   input wire logic [15:0]       BOOT_MASK,
   input wire pwp_pkg::pwp_rsp_t RSP,
   input wire logic [15:0]       MASK_OUT,
   input wire logic              KEY_ARMED,
   input wire logic              KEY_LOCKOUT
);
   import pwp_pkg::*;
   logic rq;
   logic rd;
   logic wr;
   // Boot loads swallow a request, so they never count as taken
   assign rq = REQ.valid && !BOOT_LOAD;
   assign rd = rq && !REQ.write;
   assign wr = rq && REQ.write;
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);
   property p_answer; rq |=> RSP.valid && RSP.hit == $past(REQ.code[7:1] == 7'h7D); endproperty
   a_answer: assert property (p_answer) else $error("bad answer");
   property p_quiet; !rq |=> !RSP.valid; endproperty
   a_quiet: assert property (p_quiet) else $error("stray answer");
   property p_lock_rd; rd && REQ.code == 8'hFA && KEY_LOCKOUT |=> RSP.rdata == 16'h00FF; endproperty
   a_lock_rd: assert property (p_lock_rd) else $error("bad lockout code");
   property p_open_rd; rd && REQ.code == 8'hFA && !KEY_ARMED |=> RSP.rdata == 16'h0000; endproperty
   a_open_rd: assert property (p_open_rd) else $error("bad open code");
   property p_mask_rd; rd && REQ.code == 8'hFB |=> RSP.rdata == $past(MASK_OUT); endproperty
   a_mask_rd: assert property (p_mask_rd) else $error("bad mask read");
   property p_hold; !(wr && REQ.code == 8'hFB) && !BOOT_LOAD |=> $stable(MASK_OUT); endproperty
   a_hold: assert property (p_hold) else $error("mask moved");
   property p_self; wr && REQ.code == 8'hFB && (MASK_OUT[15] || KEY_ARMED)
      |=> !RSP.accept && $stable(MASK_OUT); endproperty
   a_self: assert property (p_self) else $error("mask write taken");
   property p_save; wr && REQ.code == 8'h15 && (MASK_OUT[0] || KEY_ARMED) |=> !RSP.accept; endproperty
   a_save: assert property (p_save) else $error("save taken");
   property p_wp; wr && REQ.code == 8'h10 |=> RSP.accept == !$past(MASK_OUT[14]); endproperty
   a_wp: assert property (p_wp) else $error("bad protect answer");
   property p_key_ro; wr && REQ.code == 8'hFA && (MASK_OUT[15] || MASK_OUT[1])
      |=> !RSP.accept && $stable(KEY_ARMED); endproperty
   a_key_ro: assert property (p_key_ro) else $error("key write taken");
endmodule : pwp_monitor

bind pwp_protect pwp_monitor mon_u (.CLK_SYS, .RESET_N, .REQ, .BOOT_LOAD, .BOOT_KEY,
   .BOOT_MASK, .RSP, .MASK_OUT, .KEY_ARMED, .KEY_LOCKOUT);

// ==== pwp_host.sv ====
// Purpose: Host model issuing word reads and writes
// Assumes: Requests change on the falling edge
// Notes:   Idle fields invert so stale data is never trusted
`timescale 1ns/100ps
module pwp_host (
   input  wire logic         CLK_SYS,
   output pwp_pkg::pwp_req_t REQ
);
   import pwp_pkg::*;
   initial REQ = '0;
   task op(input logic w, input logic [7:0] c, input logic [15:0] d, input logic b);
      @(negedge CLK_SYS);
      REQ = '{1'b1, w, c, d, b};
      @(negedge CLK_SYS);
      REQ = '{1'b0, ~w, ~c, ~d, ~b};
   endtask : op
endmodule : pwp_host

// ==== tb_passkey_group_write_lock_mask.sv ====
// Purpose: Self-checking bench for the key and mask block
// Assumes: Host model drives requests, bench drives boot loads
// Notes:   Driver queues expected answers, monitor pops them
`timescale 1ns/100ps
module tb_passkey_group_write_lock_mask;
   import pwp_pkg::*;
   logic        CLK_SYS, RESET_N, BOOT_LOAD, KEY_ARMED, KEY_LOCKOUT;
   logic [15:0] BOOT_KEY, BOOT_MASK, MASK_OUT, key, d;
   pwp_req_t    REQ;
   pwp_rsp_t    RSP, exp_r;
   pwp_rsp_t    exp_q[$];
   int          errors, n_checks, seed, i;
   logic [7:0]  grp[6] = '{8'h22, 8'h20, 8'h24, 8'h42, 8'h46, 8'h25};
   logic [15:0] rdc[3] = '{16'h001F, 16'h002F, 16'h00FF};
   pwp_host host_u (.CLK_SYS, .REQ);
   pwp_protect dut_u (.CLK_SYS, .RESET_N, .REQ, .BOOT_LOAD, .BOOT_KEY, .BOOT_MASK,
      .RSP, .MASK_OUT, .KEY_ARMED, .KEY_LOCKOUT);
   initial begin
      CLK_SYS = 1'b0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end
   task print_verdict;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict
   task chk_rsp(input pwp_rsp_t e);
      n_checks++;
      if (RSP !== e) begin
         errors++;
         $display("unexpected rsp exp %h got %h", e, RSP);
      end
   endtask : chk_rsp
   task st(input logic [17:0] e);
      n_checks++;
      if ({KEY_LOCKOUT, KEY_ARMED, MASK_OUT} !== e) begin
         errors++;
         $display("unexpected status exp %h got %h", e, {KEY_LOCKOUT, KEY_ARMED, MASK_OUT});
      end
   endtask : st
   task go(input logic w, input logic [7:0] c, input logic [15:0] dd, input logic b, a,
           input logic [15:0] r);
      exp_q.push_back('{1'b1, c[7:1] == 7'h7D, a, r});
      host_u.op(w, c, dd, b);
   endtask : go
   task boot(input logic [15:0] k, m);
      @(negedge CLK_SYS);
      BOOT_LOAD = 1'b1;
      BOOT_KEY = k;
      BOOT_MASK = m;
      @(negedge CLK_SYS);
      BOOT_LOAD = 1'b0;
   endtask : boot
   task rst;
      RESET_N = 1'b0;
      repeat (20) @(negedge CLK_SYS);
      RESET_N = 1'b1;
   endtask : rst
   task fin(input int t);
      $display("test %0d ended", t);
   endtask : fin
   // Answers stand one cycle; the falling edge sees them settled
   always @(negedge CLK_SYS) begin
      if (RSP.valid === 1'b1) begin
         exp_r = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
         chk_rsp(exp_r);
      end
   end
   initial begin
      BOOT_LOAD = 1'b0;
      BOOT_KEY = '0;
      BOOT_MASK = '0;
      seed = 32'h7057D527;
      rst();
      key = 16'($random(seed)) | 16'h0001;
      go('0, 8'hFA, '0, '0, '0, 16'h0000);
      go('0, 8'hFB, '0, '0, '0, 16'h0000);
      go('1, 8'h15, '0, '0, '1, '0);
      go('1, 8'hFA, key, '0, '1, '0);
      go('1, 8'h01, key, '1, '0, '0);
      go('1, 8'h01, key, '0, '1, '0);
      go('0, 8'h22, key, '0, '0, '0);
      st(18'h0);
      fin(1);
      for (i = 0; i < 6; i++) begin
         d = 16'($random(seed));
         go('1, 8'hFB, 16'h2000 >> i, '0, '1, '0);
         go('1, grp[i], d, '0, '0, '0);
         go('1, grp[(i + 1) % 6], d, '0, '1, '0);
         go('1, 8'hFB, '0, '0, '1, '0);
         go('1, grp[i], d, '1, '0, '0);
         go('1, grp[i], d, '0, '1, '0);
      end
      go('1, 8'h10, d, '1, '1, '0);
      go('1, 8'hFB, 16'h4001, '0, '1, '0);
      go('1, 8'h10, d, '0, '0, '0);
      go('1, 8'h15, '0, '0, '0, '0);
      go('1, 8'hFB, 16'h0002, '0, '1, '0);
      go('1, 8'hFA, '0, '0, '0, '0);
      go('1, 8'h15, '0, '0, '1, '0);
      go('1, 8'hFB, '0, '0, '0, '0);
      st({2'b00, 16'h0002});
      fin(2);
      boot(key, '0);
      st({2'b01, 16'h0000});
      go('0, 8'hFA, '0, '0, '0, 16'h000F);
      go('1, 8'hFB, 16'h0100, '0, '0, '0);
      go('1, 8'h15, '0, '0, '0, '0);
      go('1, 8'hFA, ~key, '0, '0, '0);
      go('0, 8'hFA, '0, '0, '0, 16'h001F);
      go('1, 8'hFA, key, '0, '1, '0);
      go('0, 8'hFA, '0, '0, '0, 16'h0000);
      fin(3);
      boot(key, '0);
      for (i = 0; i < 3; i++) begin
         go('1, 8'hFA, key ^ 16'h8000, '0, '0, '0);
         go('0, 8'hFA, '0, '0, '0, rdc[i]);
      end
      go('1, 8'hFA, key, '0, '0, '0);
      st({2'b11, 16'h0000});
      fin(4);
      // Let the last answer be checked before reset clears it
      @(negedge CLK_SYS);
      rst();
      st(18'h0);
      go('1, 8'hFB, 16'h8000, '0, '1, '0);
      go('1, 8'hFB, '0, '0, '0, '0);
      go('1, 8'hFA, key, '0, '0, '0);
      go('1, 8'h15, '0, '0, '1, '0);
      boot('0, '0);
      go('1, 8'hFB, 16'h0001, '0, '0, '0);
      st(18'h0);
      fin(5);
      for (i = 0; i < 5 && exp_q.size() > 0; i++) @(negedge CLK_SYS);
      if (exp_q.size() > 0) errors++;
      print_verdict();
   end
endmodule : tb_passkey_group_write_lock_mask
